// [rtl/load_store_unit.sv]
// Purpose: Executes memory access instructions of a 32-bit core
// Assumes: Decoded fields at the request port, register file outside,
//          data bus holds request until ready, all inputs but rst synchronous
// Notes:   One bus transfer in flight; flags are never written
//
// Overview of operation
// - Address generate writes program counter plus offset to destination.
// - No memory instruction changes the N, Z, C or V flags.
// - Immediate loads fetch word, byte or half; short ones zero extended.
// - Stores write whole word, low byte or low halfword of source.
// - Immediate address is base or stack pointer plus offset, default zero.
// - Misaligned accesses are not performed and raise hard fault.
// - Register-offset loads return word, zero or sign extended short data.
// - Register-offset address is base plus offset register.
// - Literal load reads an aligned word within 1020 of program counter.
// - Program counter used is current instruction address plus four, low two bits cleared.
// - Multiple transfers walk consecutive words from base upward.
// - Lowest register at lowest address, increasing register order.
// - Writeback puts base plus four times count into base.
// - Push tops out at stack pointer minus four, pointer to lowest.
// - Pop reads upward from stack pointer, pointer just above last.
// - Pop with program counter branches, bit 0 goes to state bit.
`timescale 1ns/1ns
`include "lsu_regs.svh"
module load_store_unit
(
    input  wire logic           sys_clk,        // Core clock
    input  wire logic           rst,            // Asynchronous reset
    input  wire logic           req_valid,      // Instruction offered
    output logic                req_ready,      // Unit idle, takes request
    input  wire lsu_pkg::op_t   req_op,         // Instruction class
    input  wire lsu_pkg::size_t req_size,       // Single transfer width
    input  wire logic           req_signed,     // Sign-extending load
    input  wire lsu_pkg::mode_t req_mode,       // Single addressing form
    input  wire logic [2:0]     target_reg_field, // Load/store/adr register
    input  wire logic [2:0]     base_reg_field,   // Base register
    input  wire logic [2:0]     offset_reg_field, // Offset register
    input  wire logic [9:0]     req_imm,        // Byte offset, zero when omitted
    input  wire logic [31:0]    req_pc,         // Current instruction address
    input  wire logic [8:0]     req_list,       // Bits 0-7 low regs, bit 8 lr/pc
    input  wire logic           req_writeback,  // Base writeback wanted
    output logic [3:0]          rd_a_idx,       // Register read port A index
    input  wire logic [31:0]    rd_a_data,      // Register read port A data
    output logic [3:0]          rd_b_idx,       // Register read port B index
    input  wire logic [31:0]    rd_b_data,      // Register read port B data
    output logic                wr_en,          // Register write strobe
    output logic [3:0]          wr_idx,         // Register write index
    output logic [31:0]         wr_data,        // Register write value
    output logic                flag_write_en,  // Condition flag update
    output logic                bus_req,        // Data bus request
    output logic                bus_write,      // Write transfer
    output logic [31:0]         bus_addr,       // Transfer address
    output lsu_pkg::size_t      bus_size,       // Transfer size qualifier
    output logic [3:0]          bus_byte_en,    // Byte lanes
    output logic [31:0]         bus_wdata,      // Write data
    input  wire logic           bus_ready,      // Transfer complete
    input  wire logic [31:0]    bus_rdata,      // Read data
    output logic                branch_valid,   // Pop branch pulse
    output logic [31:0]         branch_target,  // Branch address
    output logic                exec_state_bit, // Execution-state bit
    output logic                hard_fault_exception, // Misalignment pulse
    output logic                instr_done      // Instruction retired pulse
);
    import lsu_pkg::*;

    state_t      state;
    state_t      next_state;
    op_t         op_q;
    size_t       size_q;
    logic        sign_q;
    mode_t       mode_q;
    logic [2:0]  tgt_q;
    logic [2:0]  base_q;
    logic [2:0]  offr_q;
    logic [9:0]  imm_q;
    logic [31:0] pc_q;
    logic [8:0]  list_q;
    logic        wb_q;
    logic [31:0] addr_q;
    logic [31:0] wb_val_q;
    logic [3:0]  cur_idx_q;
    logic        defer_base_q;
    logic [31:0] defer_val_q;
    logic        pc_pop_q;
    logic [31:0] pc_val_q;
    logic        next_wr_en;
    logic [3:0]  next_wr_idx;
    logic [31:0] next_wr_data;

    // Number of listed registers
    function automatic logic [3:0] list_count(input logic [8:0] l);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < `LSU_LIST_W; i++)
            c = c + {3'b000, l[i]};
        return c;
    endfunction

    // Lowest listed register, extra entry maps to lr or pc
    function automatic logic [3:0] list_lowest(input logic [8:0] l, input logic is_pop);
        logic [3:0] r;
        r = is_pop ? `LSU_REG_PC : `LSU_REG_LR;
        for (int i = `LSU_LIST_EXTRA - 1; i >= 0; i--)
            if (l[i])
                r = i[3:0];
        return r;
    endfunction

    // Instruction classes
    wire is_single  = (op_q == OP_LOAD) || (op_q == OP_STORE);
    wire is_multi   = (op_q == OP_MULTI_LOAD) || (op_q == OP_MULTI_STORE);
    wire is_stack   = (op_q == OP_PUSH) || (op_q == OP_POP);
    wire is_load    = (op_q == OP_LOAD) || (op_q == OP_MULTI_LOAD) || (op_q == OP_POP);
    wire use_sp     = is_stack || (is_single && mode_q == MODE_SP_IMM);

    // Address forming
    wire [31:0] imm_ext   = {22'h0, imm_q};
    wire [31:0] pc_word   = (pc_q + `LSU_PC_AHEAD) & `LSU_WORD_MASK;
    wire [31:0] pc_rel    = pc_word + imm_ext;
    wire [3:0]  count     = list_count(list_q);
    wire [31:0] span      = {26'h0, count, 2'b00};
    wire [31:0] base_imm  = rd_a_data + imm_ext;
    wire [31:0] base_reg  = rd_a_data + rd_b_data;
    wire [31:0] push_low  = rd_a_data - span;
    wire [31:0] single_addr = (mode_q == MODE_LITERAL) ? pc_rel :
                              (mode_q == MODE_REG)     ? base_reg : base_imm;
    wire [31:0] calc_addr = is_single ? single_addr :
                            (op_q == OP_PUSH) ? push_low : rd_a_data;
    wire [31:0] calc_wb   = (op_q == OP_PUSH) ? push_low : rd_a_data + span;
    wire [1:0]  calc_size = is_single ? size_q : SIZE_WORD;
    wire        misalign  = (calc_size == SIZE_WORD) ? (calc_addr[1:0] != 2'b00) :
                            (calc_size == SIZE_HALF) ? calc_addr[0] : 1'b0;

    // Current element of the transfer
    wire [3:0]  elem_idx  = is_single ? {1'b0, tgt_q} : list_lowest(list_q, op_q == OP_POP);
    wire [8:0]  list_rest = list_q & (list_q - 9'h001);
    wire        last_elem = (list_rest == 9'h000);
    wire        elem_base = is_multi && (cur_idx_q == {1'b0, base_q});
    wire        base_listed = list_q[base_q];

    // Lane formatting of store and load data
    logic [31:0] store_data;
    logic [3:0]  store_be;
    logic [31:0] load_data;
    lsu_lane_format u_lane
    (
        .size       (size_t'(calc_size)),
        .sign_ext   (sign_q),
        .lane       (addr_q[1:0]),
        .store_src  (rd_a_data),
        .load_raw   (bus_rdata),
        .store_data (store_data),
        .store_be   (store_be),
        .load_data  (load_data)
    );

    // Read port selection
    assign rd_a_idx  = (state == S_ISSUE) ? elem_idx :
                       use_sp ? `LSU_REG_SP : {1'b0, base_q};
    assign rd_b_idx  = {1'b0, offr_q};
    assign req_ready = (state == S_IDLE);
    assign bus_req   = (state == S_BUS);
    assign flag_write_en = 1'b0;

    // Next state
    always_comb
    begin
        next_state = state;
        case (state)
            S_IDLE:   next_state = req_valid ? S_CALC : S_IDLE;
            S_CALC:   next_state = (op_q == OP_ADR) ? S_FINISH :
                                   misalign ? S_IDLE : S_ISSUE;
            S_ISSUE:  next_state = S_BUS;
            S_BUS:    next_state = !bus_ready ? S_BUS :
                                   last_elem ? S_FINISH : S_ISSUE;
            S_FINISH: next_state = S_IDLE;
            default:  next_state = S_IDLE;
        endcase
    end

    // Register file write selection
    always_comb
    begin
        next_wr_en   = 1'b0;
        next_wr_idx  = {1'b0, tgt_q};
        next_wr_data = load_data;
        if (state == S_CALC && op_q == OP_ADR)
        begin
            next_wr_en   = 1'b1;
            next_wr_data = pc_rel;
        end
        else if (state == S_BUS && bus_ready && is_load)
        begin
            // Base and pc loads are held back to the end
            next_wr_en   = !(elem_base || cur_idx_q == `LSU_REG_PC);
            next_wr_idx  = cur_idx_q;
        end
        else if (state == S_FINISH && defer_base_q)
        begin
            next_wr_en   = 1'b1;
            next_wr_idx  = {1'b0, base_q};
            next_wr_data = defer_val_q;
        end
        else if (state == S_FINISH && (is_stack || (is_multi && wb_q)))
        begin
            next_wr_en   = 1'b1;
            next_wr_idx  = is_stack ? `LSU_REG_SP : {1'b0, base_q};
            next_wr_data = wb_val_q;
        end
    end

    // State and register writes
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state   <= S_IDLE;
            wr_en   <= 1'b0;
            wr_idx  <= 4'h0;
            wr_data <= 32'h0000_0000;
        end
        else
        begin
            state   <= next_state;
            wr_en   <= next_wr_en;
            wr_idx  <= next_wr_idx;
            wr_data <= next_wr_data;
        end
    end

    // Request capture
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            op_q <= OP_ADR;  size_q <= SIZE_WORD;  sign_q <= 1'b0;  mode_q <= MODE_IMM;
            tgt_q <= 3'h0;  base_q <= 3'h0;  offr_q <= 3'h0;  imm_q <= 10'h000;
            pc_q <= 32'h0000_0000;  wb_q <= 1'b0;
        end
        else if (state == S_IDLE && req_valid)
        begin
            op_q <= req_op;  size_q <= req_size;  sign_q <= req_signed;  mode_q <= req_mode;
            tgt_q <= target_reg_field;  base_q <= base_reg_field;
            offr_q <= offset_reg_field;  imm_q <= req_imm;
            pc_q <= req_pc;  wb_q <= req_writeback && !(req_op == OP_MULTI_LOAD
                                      && req_list[base_reg_field]);
        end
    end

    // Transfer walk: address, list and element
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            list_q <= 9'h000;  addr_q <= 32'h0000_0000;
            wb_val_q <= 32'h0000_0000;  cur_idx_q <= 4'h0;
        end
        else if (state == S_IDLE && req_valid)
            list_q <= (req_op == OP_LOAD || req_op == OP_STORE) ? 9'h001 : req_list;
        else if (state == S_CALC)
        begin
            addr_q   <= calc_addr;
            wb_val_q <= calc_wb;
        end
        else if (state == S_ISSUE)
            cur_idx_q <= elem_idx;
        else if (state == S_BUS && bus_ready)
        begin
            list_q <= list_rest;
            addr_q <= addr_q + `LSU_WORD_STEP;
        end
    end

    // Bus transfer fields, one per element
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bus_write <= 1'b0;  bus_addr <= 32'h0000_0000;  bus_size <= SIZE_WORD;
            bus_byte_en <= 4'h0;  bus_wdata <= 32'h0000_0000;
        end
        else if (state == S_ISSUE)
        begin
            bus_write   <= !is_load;
            bus_addr    <= addr_q;
            bus_size    <= size_t'(calc_size);
            bus_byte_en <= store_be;
            bus_wdata   <= is_load ? 32'h0000_0000 : store_data;
        end
    end

    // Held-back base and pc values
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            defer_base_q <= 1'b0;  defer_val_q <= 32'h0000_0000;
            pc_pop_q <= 1'b0;  pc_val_q <= 32'h0000_0000;
        end
        else if (state == S_CALC)
        begin
            defer_base_q <= 1'b0;
            pc_pop_q     <= 1'b0;
        end
        else if (state == S_BUS && bus_ready && op_q == OP_MULTI_LOAD && elem_base)
        begin
            defer_base_q <= base_listed;
            defer_val_q  <= bus_rdata;
        end
        else if (state == S_BUS && bus_ready && op_q == OP_POP && cur_idx_q == `LSU_REG_PC)
        begin
            pc_pop_q <= 1'b1;
            pc_val_q <= bus_rdata;
        end
    end

    // Completion, branch and fault pulses
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            instr_done <= 1'b0;  branch_valid <= 1'b0;  branch_target <= 32'h0000_0000;
            exec_state_bit <= 1'b1;  hard_fault_exception <= 1'b0;
        end
        else
        begin
            instr_done   <= (state == S_FINISH);
            branch_valid <= (state == S_FINISH) && pc_pop_q;
            hard_fault_exception <= (state == S_CALC) && (op_q != OP_ADR) && misalign;
            if (state == S_FINISH && pc_pop_q)
            begin
                branch_target  <= pc_val_q & 32'hffff_fffe;
                exec_state_bit <= pc_val_q[0];
            end
        end
    end
endmodule

// [rtl/lsu_regs.svh]
// Purpose: Shared constants of the load/store unit
// Assumes: Included by bare name from the load_store_unit module
// Notes:   Definitions only
`ifndef LSU_REGS_SVH
`define LSU_REGS_SVH

// Architectural register numbers
`define LSU_REG_SP       4'hd
`define LSU_REG_LR       4'he
`define LSU_REG_PC       4'hf

// Program counter runs this far ahead of the executing instruction
`define LSU_PC_AHEAD     32'h0000_0004
// Word step between multiple-transfer accesses
`define LSU_WORD_STEP    32'h0000_0004
// Mask that clears the low two address bits
`define LSU_WORD_MASK    32'hffff_fffc

// Extra list entry: link register on push, program counter on pop
`define LSU_LIST_EXTRA   8
`define LSU_LIST_W       9

`endif

// [rtl/lsu_pkg.sv]
// Purpose: Types of the load/store unit
// Assumes: Nothing beyond the constants header
// Notes:   Encodings written out
package lsu_pkg;

    // Instruction class handed over by the decoder
    typedef enum logic [2:0] {
        OP_ADR        = 3'b000,
        OP_LOAD       = 3'b001,
        OP_STORE      = 3'b010,
        OP_MULTI_LOAD = 3'b011,
        OP_MULTI_STORE= 3'b100,
        OP_PUSH       = 3'b101,
        OP_POP        = 3'b110
    } op_t;

    // Transfer width, also driven as the bus size qualifier
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'b00,
        SIZE_HALF = 2'b01,
        SIZE_WORD = 2'b10
    } size_t;

    // Addressing form of single transfers
    typedef enum logic [1:0] {
        MODE_IMM     = 2'b00,
        MODE_SP_IMM  = 2'b01,
        MODE_REG     = 2'b10,
        MODE_LITERAL = 2'b11
    } mode_t;

    // Sequencer states
    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_CALC   = 3'b001,
        S_ISSUE  = 3'b010,
        S_BUS    = 3'b011,
        S_FINISH = 3'b100
    } state_t;

endpackage

// [rtl/lsu_lane_format.sv]
// Purpose: Byte-lane placement of store data and extension of load data
// Assumes: Little-endian 32-bit data bus with byte lanes by address
// Notes:   Purely combinational
`timescale 1ns/1ns
module lsu_lane_format
(
    input  wire lsu_pkg::size_t size,        // Transfer width
    input  wire logic           sign_ext,    // Sign-extend short loads
    input  wire logic [1:0]     lane,        // Low address bits
    input  wire logic [31:0]    store_src,   // Source register value
    input  wire logic [31:0]    load_raw,    // Bus read data
    output logic      [31:0]    store_data,  // Lane-placed write data
    output logic      [3:0]     store_be,    // Byte enables
    output logic      [31:0]    load_data    // Extended register value
);
    import lsu_pkg::*;

    wire [4:0]  shift_bits = {lane, 3'b000};
    wire [31:0] raw_down   = load_raw >> shift_bits;
    wire        byte_msb   = sign_ext & raw_down[7];
    wire        half_msb   = sign_ext & raw_down[15];

    // Word stores send the whole source, short stores only its low byte or low halfword
    assign store_data = (size == SIZE_WORD) ? store_src :
                        (size == SIZE_HALF) ? ({16'h0000, store_src[15:0]} << shift_bits) :
                                              ({24'h000000, store_src[7:0]} << shift_bits);
    assign store_be   = (size == SIZE_WORD) ? 4'hf :
                        (size == SIZE_HALF) ? (4'h3 << lane) :
                                              (4'h1 << lane);

    // Short loads zero- or sign-extended to 32 bits
    assign load_data  = (size == SIZE_WORD) ? raw_down :
                        (size == SIZE_HALF) ? {{16{half_msb}}, raw_down[15:0]} :
                                              {{24{byte_msb}}, raw_down[7:0]};
endmodule

// [bench/load_store_unit_assertions.sv]
// Purpose: Port-level checks of the load/store unit
// Assumes: Bound into load_store_unit, one clock domain
// Notes:   Bus, fault and branch timing judged at the ports
`timescale 1ns/1ns
module load_store_unit_assertions
(
    input wire logic           sys_clk,              // Clock
    input wire logic           rst,                  // Reset
    input wire logic           req_valid,            // Offer
    input wire logic           req_ready,            // Idle
    input wire lsu_pkg::op_t   req_op,               // Class
    input wire logic           bus_req,              // Bus request
    input wire logic           bus_ready,            // Bus done
    input wire logic           bus_write,            // Write
    input wire logic [31:0]    bus_addr,             // Address
    input wire lsu_pkg::size_t bus_size,             // Size
    input wire logic [3:0]     bus_byte_en,          // Lanes
    input wire logic           wr_en,                // Reg write
    input wire logic           flag_write_en,        // Flags
    input wire logic           branch_valid,         // Branch
    input wire logic           hard_fault_exception, // Fault
    input wire logic           instr_done            // Done
);
    import lsu_pkg::*;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Flag, timing and bus checks
    chk_flags_kept: assert property (flag_write_en == 1'b0)
        else $error("condition flag write seen");
    chk_adr_retires: assert property
        (req_valid && req_ready && req_op == OP_ADR |-> ##[2:4] instr_done)
        else $error("address generate did not retire");
    chk_bus_hold: assert property
        (bus_req && !bus_ready |=> bus_req && $stable(bus_addr) && $stable(bus_size))
        else $error("bus request changed before ready");
    chk_busy_refuse: assert property (bus_req |-> !req_ready)
        else $error("request port ready during bus transfer");
    chk_bus_align: assert property
        (bus_req |-> (bus_size == SIZE_WORD ? bus_addr[1:0] == 2'b00
                      : !(bus_size == SIZE_HALF && bus_addr[0])))
        else $error("misaligned bus transfer issued");
    chk_store_lanes: assert property
        (bus_req && bus_write |-> bus_byte_en == (bus_size == SIZE_WORD ? 4'hf
                      : (bus_size == SIZE_HALF ? 4'h3 : 4'h1) << bus_addr[1:0]))
        else $error("store byte lanes wrong");
    chk_fault_quiet: assert property
        (hard_fault_exception |-> !bus_req && !wr_en && !$past(bus_req))
        else $error("fault with bus or register activity");
    chk_branch_after: assert property (branch_valid |-> !bus_req && !$past(bus_req))
        else $error("branch committed while reads pending");
endmodule

bind load_store_unit load_store_unit_assertions chk (.*);

// [bench/lsu_mem_model.sv]
// Purpose: Behavioural system memory on the data bus
// Assumes: 2 KB word array, zero to two random wait states
// Notes:   Read data is scrambled while no transfer completes
`timescale 1ns/1ns
module lsu_mem_model
(
    input  wire logic        sys_clk,     // Clock
    input  wire logic        rst,         // Reset
    input  wire logic        bus_req,     // Request
    input  wire logic        bus_write,   // Write
    input  wire logic [31:0] bus_addr,    // Address
    input  wire logic [3:0]  bus_byte_en, // Lanes
    input  wire logic [31:0] bus_wdata,   // Write data
    output logic             bus_ready,   // Done
    output logic      [31:0] bus_rdata    // Read data
);
    logic [31:0] mem [0:511];
    logic [1:0]  wait_cnt;
    logic [31:0] last = 32'h5a5a_a5a5;

    // Answer once the wait states have run out
    assign bus_ready = bus_req && wait_cnt == 2'h0;
    assign bus_rdata = bus_ready ? mem[bus_addr[10:2]] : ~last;

    // Complete a transfer and draw the next wait
    always @(posedge sys_clk or posedge rst)
        if (rst)
            wait_cnt <= 2'h0;
        else if (bus_ready)
        begin
            wait_cnt <= 2'($urandom_range(2, 0));
            last <= bus_rdata;
            for (int k = 0; k < 4; k++)
                if (bus_write && bus_byte_en[k])
                    mem[bus_addr[10:2]][8*k +: 8] <= bus_wdata[8*k +: 8];
        end
        else if (bus_req)
            wait_cnt <= wait_cnt - 2'h1;
endmodule

// [bench/load_store_unit_tb.sv]
// Purpose: Self-checking bench of the load/store unit
// Assumes: Register file here, memory in lsu_mem_model
// Notes:   Random single transfers, then directed multiple and stack cases
`timescale 1ns/1ns
module load_store_unit_tb;
    import lsu_pkg::*;
    logic        sys_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_signed = 1'b0;
    logic        req_writeback = 1'b0, req_ready, wr_en, flag_write_en, bus_req, bus_write;
    logic        bus_ready, branch_valid, exec_state_bit, hard_fault_exception, instr_done;
    logic        flt, br_seen, st;
    op_t         req_op = OP_ADR;
    size_t       req_size = SIZE_WORD, bus_size, s, bsz;
    mode_t       req_mode = MODE_IMM, m;
    logic [2:0]  target_reg_field = 3'h0, base_reg_field = 3'h0, offset_reg_field = 3'h0, t;
    logic [9:0]  req_imm = 10'h0, i;
    logic [8:0]  req_list = 9'h0;
    logic [3:0]  rd_a_idx, rd_b_idx, wr_idx, bus_byte_en;
    logic [31:0] req_pc = 32'h0, rd_a_data, rd_b_data, wr_data, bus_addr, bus_wdata;
    logic [31:0] bus_rdata, branch_target, a, old;
    logic [31:0] regs [0:15];
    int          err_count = 0, comparisons = 0;

    load_store_unit DUT (.*);
    lsu_mem_model MEM (.*);

    // Clock, register file and branch capture
    always #5 sys_clk = ~sys_clk;
    assign rd_a_data = regs[rd_a_idx];
    assign rd_b_data = regs[rd_b_idx];
    always @(posedge sys_clk)
    begin
        if (wr_en === 1'b1)
            regs[wr_idx] <= wr_data;
        if (branch_valid === 1'b1)
            br_seen <= 1'b1;
        if (bus_ready === 1'b1)
            bsz <= bus_size;
    end

    // Load result or memory word after a store
    function automatic logic [31:0] expect_val(logic [31:0] w, d, logic [1:0] l, size_t z,
                                               logic g, logic wr);
        logic [31:0] mk;
        logic [31:0] v;
        mk = (z == SIZE_WORD) ? 32'hffff_ffff : (z == SIZE_HALF) ? 32'hffff : 32'hff;
        v = (w >> {l, 3'b000}) & mk;
        if (g)
            v = v | ~mk & {32{v[{z, 3'b111}]}};
        return wr ? (w & ~(mk << {l, 3'b000})) | ((d & mk) << {l, 3'b000}) : v;
    endfunction

    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_of_test();
        if (err_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Offer one instruction, wait until it retires or faults
    task automatic go(op_t o, size_t z, mode_t md, logic [2:0] ft, fb, fo, logic [9:0] im,
                      logic [8:0] ls, logic wb);
        req_op = o;
        req_size = z;
        req_mode = md;
        target_reg_field = ft;
        base_reg_field = fb;
        offset_reg_field = fo;
        req_imm = im;
        req_list = ls;
        req_writeback = wb;
        req_valid = 1'b1;
        @(negedge sys_clk);
        req_valid = 1'b0;
        while (instr_done !== 1'b1 && hard_fault_exception !== 1'b1)
            @(negedge sys_clk);
        flt = hard_fault_exception;
        @(negedge sys_clk);
    endtask

    // Hang guard
    initial
    begin
        #200000;
        err_count++;
        end_of_test();
    end

    initial
    begin
        void'($urandom(32'h7a6e));
        for (int k = 0; k < 512; k++)
            MEM.mem[k] = $urandom;
        for (int k = 0; k < 16; k++)
            regs[k] = $urandom;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        // Random single loads and stores on legal offsets
        repeat (60)
        begin
            s = size_t'($urandom_range(2, 0));
            m = mode_t'($urandom_range(2, 0));
            if (s != SIZE_WORD && m == MODE_SP_IMM)
                m = MODE_IMM;
            st = 1'($urandom_range(1, 0));
            req_signed = !st && m == MODE_REG && $urandom_range(1, 0);
            t = 3'($urandom_range(7, 0));
            i = 10'($urandom_range(31, 0)) << s;
            if (m == MODE_SP_IMM)
                i = 10'($urandom_range(255, 0)) << 2;
            regs[t + 3'd1] = 32'($urandom_range(127, 0)) << 2;
            regs[t + 3'd2] = 32'(i);
            regs[13] = 32'($urandom_range(127, 0)) << 2;
            a = (m == MODE_SP_IMM) ? regs[13] : regs[t + 3'd1];
            a = a + ((m == MODE_REG) ? regs[t + 3'd2] : 32'(i));
            old = expect_val(MEM.mem[a[10:2]], regs[t], a[1:0], s, req_signed, st);
            go(st ? OP_STORE : OP_LOAD, s, m, t, t + 3'd1, t + 3'd2, i, 9'h0, 1'b0);
            check("single", old, st ? MEM.mem[a[10:2]] : regs[t]);
            check("bus_size", 32'(s), 32'(bsz));
        end
        // Misaligned halfword store is dropped and faults
        regs[1] = 32'h0000_0101;
        old = MEM.mem[64];
        go(OP_STORE, SIZE_HALF, MODE_IMM, 3'h0, 3'h1, 3'h2, 10'h0, 9'h0, 1'b0);
        check("fault", 32'h1, 32'(flt));
        check("no_write", old, MEM.mem[64]);
        // Address generate and literal load from the program counter
        req_pc = 32'h0000_0100;
        go(OP_ADR, SIZE_WORD, MODE_IMM, 3'h5, 3'h0, 3'h0, 10'd996, 9'h0, 1'b0);
        check("adr", 32'h0000_0104 + 32'd996, regs[5]);
        req_pc = 32'h0000_0102;
        go(OP_LOAD, SIZE_WORD, MODE_LITERAL, 3'h6, 3'h0, 3'h0, 10'h8, 9'h0, 1'b0);
        check("literal", MEM.mem[67], regs[6]);
        // Multiple store with writeback, multiple load listing its base
        regs[2] = 32'h0000_0200;
        go(OP_MULTI_STORE, SIZE_WORD, MODE_IMM, 3'h0, 3'h2, 3'h0, 10'h0, 9'h08a, 1'b1);
        check("stm_r1", regs[1], MEM.mem[128]);
        check("stm_r3", regs[3], MEM.mem[129]);
        check("stm_r7", regs[7], MEM.mem[130]);
        check("stm_wb", 32'h0000_020c, regs[2]);
        regs[0] = 32'h0000_0240;
        go(OP_MULTI_LOAD, SIZE_WORD, MODE_IMM, 3'h0, 3'h0, 3'h0, 10'h0, 9'h019, 1'b0);
        check("ldm_r3", MEM.mem[145], regs[3]);
        check("ldm_r4", MEM.mem[146], regs[4]);
        check("ldm_base", MEM.mem[144], regs[0]);
        // Push with link register, pop with program counter
        regs[13] = 32'h0000_0300;
        go(OP_PUSH, SIZE_WORD, MODE_IMM, 3'h0, 3'h0, 3'h0, 10'h0, 9'h104, 1'b0);
        check("push_r2", regs[2], MEM.mem[190]);
        check("push_lr", regs[14], MEM.mem[191]);
        check("push_sp", 32'h0000_02f8, regs[13]);
        regs[13] = 32'h0000_02f0;
        MEM.mem[190] = 32'h0000_0455;
        br_seen = 1'b0;
        go(OP_POP, SIZE_WORD, MODE_IMM, 3'h0, 3'h0, 3'h0, 10'h0, 9'h141, 1'b0);
        check("pop_r0", MEM.mem[188], regs[0]);
        check("pop_r6", MEM.mem[189], regs[6]);
        check("pop_sp", 32'h0000_02fc, regs[13]);
        check("pop_target", 32'h0000_0454, branch_target);
        check("pop_state", 32'h3, {30'h0, br_seen, exec_state_bit});
        end_of_test();
    end
endmodule
